// >>> src/evc_pkg.sv
// Package with vector numbers, control bit positions and classification types.
package evc_pkg;

  // Width of a vector number and the size of the vector space.
  localparam int EVC_VEC_W = 8;
  localparam int EVC_VEC_COUNT = 256;
  localparam logic [7:0] EVC_VEC_PREDEF_LAST = 8'h1F;

  // Fixed vector numbers of the predefined sources.
  localparam logic [7:0] EVC_VEC_DIVIDE = 8'h00;
  localparam logic [7:0] EVC_VEC_DEBUG = 8'h01;
  localparam logic [7:0] EVC_VEC_NMI = 8'h02;
  localparam logic [7:0] EVC_VEC_BREAK = 8'h03;
  localparam logic [7:0] EVC_VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] EVC_VEC_BOUND = 8'h05;
  localparam logic [7:0] EVC_VEC_INVOP = 8'h06;
  localparam logic [7:0] EVC_VEC_DEVNA = 8'h07;
  localparam logic [7:0] EVC_VEC_DOUBLE = 8'h08;
  localparam logic [7:0] EVC_VEC_RSV9 = 8'h09;
  localparam logic [7:0] EVC_VEC_TASKST = 8'h0A;
  localparam logic [7:0] EVC_VEC_SEGABS = 8'h0B;
  localparam logic [7:0] EVC_VEC_STACK = 8'h0C;
  localparam logic [7:0] EVC_VEC_GPROT = 8'h0D;
  localparam logic [7:0] EVC_VEC_PAGE = 8'h0E;
  localparam logic [7:0] EVC_VEC_RSV15 = 8'h0F;
  localparam logic [7:0] EVC_VEC_FPPEND = 8'h10;
  localparam logic [7:0] EVC_VEC_ALIGN = 8'h11;
  localparam logic [7:0] EVC_VEC_MCHECK = 8'h12;
  localparam logic [7:0] EVC_VEC_SIMDFP = 8'h13;
  localparam logic [7:0] EVC_VEC_RSV_LO = 8'h14;
  localparam logic [7:0] EVC_VEC_RSV_HI = 8'h1D;
  localparam logic [7:0] EVC_VEC_SECURE = 8'h1E;
  localparam logic [7:0] EVC_VEC_RSV31 = 8'h1F;

  // Bit positions in control register zero and control register four.
  localparam int EVC_CR0_EM = 2;
  localparam int EVC_CR0_TS = 3;
  localparam int EVC_CR0_AM = 18;
  localparam int EVC_CR0_PG = 31;
  localparam int EVC_CR4_MCE = 6;
  localparam logic [31:0] EVC_CR0_RESET = 32'h0000_0000;
  localparam logic [31:0] EVC_CR4_RESET = 32'h0000_0000;

  // Floating-point condition flags and media mask field layout.
  localparam int EVC_FP_FLAGS_W = 6;
  localparam int EVC_MEDIA_MASK_LSB = 7;
  localparam int EVC_MEDIA_CSR_W = 16;

  // Exception type, precision and class as carried with each vector.
  typedef enum logic [1:0] {EVC_KIND_NONE, EVC_KIND_FAULT, EVC_KIND_TRAP, EVC_KIND_ABORT}
    evc_kind_type;
  typedef enum logic [1:0] {EVC_PREC_NA, EVC_PREC_YES, EVC_PREC_NO} evc_prec_type;
  typedef enum logic [1:0] {EVC_CLS_NONE, EVC_CLS_BENIGN, EVC_CLS_CONTRIB} evc_class_type;

  // Origin of the delivered event.
  typedef enum logic [1:0] {EVC_SRC_EXC, EVC_SRC_SOFT, EVC_SRC_NMI, EVC_SRC_EXT} evc_src_type;

endpackage : evc_pkg

// >>> src/evc_class_lut.sv
// Fixed lookup from a vector number to its type, precision and class.
`timescale 1ns/1ps
`default_nettype none
module evc_class_lut (
  // Vector to classify.
  input wire logic [7:0] vector,
  // Classification of that vector.
  output var evc_pkg::evc_kind_type kind,
  output var evc_pkg::evc_prec_type prec,
  output var evc_pkg::evc_class_type cls,
  output logic reserved
);
  import evc_pkg::*;

  // Table of the predefined vectors; vectors above the predefined range are unclassified.
  always_comb begin
    kind = EVC_KIND_NONE;
    prec = EVC_PREC_NA;
    cls = EVC_CLS_NONE;
    reserved = 1'b0;
    if (vector == EVC_VEC_DIVIDE) begin
      kind = EVC_KIND_FAULT; // RULE_09
      prec = EVC_PREC_YES;
      cls = EVC_CLS_CONTRIB;
    end else if (vector == EVC_VEC_DEBUG) begin
      kind = EVC_KIND_FAULT; // RULE_10
      prec = EVC_PREC_YES;
    end else if (vector == EVC_VEC_NMI) begin
      kind = EVC_KIND_NONE; // RULE_19
    end else if (vector == EVC_VEC_BREAK || vector == EVC_VEC_OVERFLOW) begin
      kind = EVC_KIND_TRAP; // RULE_19
      prec = EVC_PREC_YES;
      cls = EVC_CLS_BENIGN;
    end else if (vector >= EVC_VEC_BOUND && vector <= EVC_VEC_DEVNA) begin
      kind = EVC_KIND_FAULT; // RULE_19
      prec = EVC_PREC_YES;
      cls = EVC_CLS_BENIGN;
    end else if (vector == EVC_VEC_DOUBLE) begin
      kind = EVC_KIND_ABORT; // RULE_11
      prec = EVC_PREC_NO;
    end else if (vector >= EVC_VEC_TASKST && vector <= EVC_VEC_GPROT) begin
      kind = EVC_KIND_FAULT; // RULE_12 RULE_13 RULE_14
      prec = EVC_PREC_YES;
      cls = EVC_CLS_CONTRIB;
    end else if (vector == EVC_VEC_PAGE) begin
      kind = EVC_KIND_FAULT; // RULE_15
      prec = EVC_PREC_YES;
      cls = EVC_CLS_CONTRIB;
    end else if (vector == EVC_VEC_FPPEND) begin
      kind = EVC_KIND_FAULT; // RULE_19
      prec = EVC_PREC_NO;
    end else if (vector == EVC_VEC_ALIGN) begin
      kind = EVC_KIND_FAULT; // RULE_19
      prec = EVC_PREC_YES;
      cls = EVC_CLS_BENIGN;
    end else if (vector == EVC_VEC_MCHECK) begin
      kind = EVC_KIND_ABORT; // RULE_19
      prec = EVC_PREC_NO;
    end else if (vector == EVC_VEC_SIMDFP) begin
      kind = EVC_KIND_FAULT; // RULE_16
      prec = EVC_PREC_YES;
    end else if (vector == EVC_VEC_SECURE) begin
      prec = EVC_PREC_YES; // RULE_17
      cls = EVC_CLS_CONTRIB;
    end else if (vector <= EVC_VEC_PREDEF_LAST) begin
      reserved = 1'b1; // RULE_07
    end
  end

endmodule : evc_class_lut
`default_nettype wire

// >>> src/evc_core.sv
// Exception and interrupt front end: vector selection, masking and classification.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Legacy FP conditions masked by control word; unmasked ones raise vector 16.
// RULE_02: Unmasked media FP conditions raise vector 19; masks sit in media control register.
// RULE_03: Masked media FP conditions skip delivery and get default handling.
// RULE_04: Disabled exceptions are never recognized; masked ones are recognized, not delivered.
// RULE_05: Privilege level zero may disable alignment, device-unavailable, machine-check.
// RULE_06: Up to 256 vectors, each indexing one handler.
// RULE_07: Vectors 0 to 31 predefined; 9, 15, 20 to 29, 31 reserved.
// RULE_08: Software interrupts may use any vector 0 to 255.
// RULE_09: Divide error is vector 0, a fault.
// RULE_10: Debug is vector 1, fault or trap by cause.
// RULE_11: Exception during handling raises vector 8, an imprecise abort.
// RULE_12: Invalid task-state is vector 10.
// RULE_13: Stack exception is vector 12, precise contributory fault.
// RULE_14: General protection is vector 13, precise fault.
// RULE_15: Page fault, vector 14, only while paging is enabled.
// RULE_16: SIMD floating-point is vector 19, precise fault.
// RULE_17: Security exception is vector 30, precise contributory.
// RULE_18: Maskable external interrupts use any vector, benign, no type or precision.
// RULE_19: Fixed assignments for vectors 2 to 7 and 16 to 18.
// RULE_20: External interrupts delivered only while enable flag set, else held pending.
// RULE_21: Accepted NMI blocks further NMIs until interrupt return; enable flag ignored.
module evc_core #(
  parameter int FP_FLAGS_W = evc_pkg::EVC_FP_FLAGS_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control register writes from system software.
  input wire logic cr_wr_zero,
  input wire logic cr_wr_four,
  input wire logic [31:0] cr_wdata,
  input wire logic [1:0] current_privilege_level,
  // Synchronous exception requests from execution, one-cycle pulses.
  input wire logic divide_error_exc,
  input wire logic debug_exc,
  input wire logic debug_is_trap,
  input wire logic breakpoint_exc,
  input wire logic overflow_exc,
  input wire logic bound_range_exc,
  input wire logic invalid_opcode_exc,
  input wire logic device_unavailable_exc,
  input wire logic invalid_task_state_exc,
  input wire logic segment_absent_exc,
  input wire logic stack_exc,
  input wire logic general_protection_exc,
  input wire logic page_fault_exc,
  input wire logic alignment_check_exc,
  input wire logic machine_check_exc,
  input wire logic security_exc,
  // Floating-point condition reports and their masks.
  input wire logic fp_exc_valid,
  input wire logic [FP_FLAGS_W-1:0] fp_status_word,
  input wire logic [FP_FLAGS_W-1:0] fp_control_word,
  input wire logic media_exc_valid,
  input wire logic [FP_FLAGS_W-1:0] media_exc_flags,
  input wire logic [15:0] media_ctrl_status_reg,
  // Software interrupt instruction.
  input wire logic soft_int_req,
  input wire logic [7:0] soft_int_vector,
  // External interrupt inputs and flow control.
  input wire logic maskable_external_irq,
  input wire logic [7:0] ext_irq_vector,
  input wire logic interrupt_enable_flag,
  input wire logic nmi_req,
  input wire logic interrupt_return_instr,
  input wire logic handler_entered,
  // Delivery to the vector table walker.
  output logic deliver_valid,
  output logic [7:0] deliver_vector,
  output var evc_pkg::evc_kind_type deliver_kind,
  output var evc_pkg::evc_prec_type deliver_prec,
  output var evc_pkg::evc_class_type deliver_class,
  output var evc_pkg::evc_src_type deliver_src,
  output logic deliver_reserved,
  // Status toward the core and the interrupt controller.
  output logic ext_irq_ack,
  output logic exc_recognized,
  output logic fp_default_handled,
  output logic media_default_handled,
  output logic nmi_blocked,
  output logic handling_busy,
  output logic [31:0] control_reg_zero,
  output logic [31:0] control_reg_four
);
  import evc_pkg::*;

  logic [31:0] cr0_q, cr4_q;
  logic nmi_pend_q, nmi_block_q, handling_q;
  logic fp_unmasked, fp_masked, media_unmasked, media_masked;
  logic ac_en, nm_en, mc_en, pg_en;
  logic [FP_FLAGS_W-1:0] media_mask;
  logic sel_hit, exc_any, lut_rsv;
  logic [7:0] sel_vec;
  evc_src_type sel_src;
  evc_kind_type lut_kind;
  evc_prec_type lut_prec;
  evc_class_type lut_cls;

  // Control registers change only from the most privileged level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cr0_q <= EVC_CR0_RESET;
      cr4_q <= EVC_CR4_RESET;
    end else if (current_privilege_level == 2'h0) begin
      if (cr_wr_zero) begin
        cr0_q <= cr_wdata; // RULE_05
      end
      if (cr_wr_four) begin
        cr4_q <= cr_wdata; // RULE_05
      end
    end
  end

  // Enables derived from the control registers.
  assign ac_en = cr0_q[EVC_CR0_AM]; // RULE_05
  assign nm_en = cr0_q[EVC_CR0_TS] | cr0_q[EVC_CR0_EM]; // RULE_05
  assign mc_en = cr4_q[EVC_CR4_MCE]; // RULE_05
  assign pg_en = cr0_q[EVC_CR0_PG]; // RULE_15

  // Masking of floating-point conditions, legacy and media.
  assign media_mask = media_ctrl_status_reg[EVC_MEDIA_MASK_LSB +: FP_FLAGS_W];
  assign fp_unmasked = fp_exc_valid && |(fp_status_word & ~fp_control_word); // RULE_01
  assign fp_masked = fp_exc_valid && |fp_status_word && !fp_unmasked; // RULE_04
  assign media_unmasked = media_exc_valid && |(media_exc_flags & ~media_mask); // RULE_02
  assign media_masked = media_exc_valid && |media_exc_flags && !media_unmasked; // RULE_03

  // Any recognized synchronous exception this cycle; disabled ones and masked FP conditions are left out.
  assign exc_any = divide_error_exc | debug_exc | breakpoint_exc | overflow_exc |
                   bound_range_exc | invalid_opcode_exc | (device_unavailable_exc & nm_en) |
                   invalid_task_state_exc | segment_absent_exc | stack_exc |
                   general_protection_exc | (page_fault_exc & pg_en) |
                   (alignment_check_exc & ac_en) | (machine_check_exc & mc_en) |
                   security_exc | fp_unmasked | media_unmasked; // RULE_04

  // Priority selection: machine check, exceptions by vector, software, NMI, external.
  always_comb begin
    sel_hit = 1'b1;
    sel_vec = EVC_VEC_DIVIDE;
    sel_src = EVC_SRC_EXC;
    if (machine_check_exc && mc_en) begin
      sel_vec = EVC_VEC_MCHECK; // RULE_19
    end else if (divide_error_exc) begin
      sel_vec = EVC_VEC_DIVIDE; // RULE_09
    end else if (debug_exc) begin
      sel_vec = EVC_VEC_DEBUG; // RULE_10
    end else if (breakpoint_exc) begin
      sel_vec = EVC_VEC_BREAK; // RULE_19
    end else if (overflow_exc) begin
      sel_vec = EVC_VEC_OVERFLOW; // RULE_19
    end else if (bound_range_exc) begin
      sel_vec = EVC_VEC_BOUND; // RULE_19
    end else if (invalid_opcode_exc) begin
      sel_vec = EVC_VEC_INVOP; // RULE_19
    end else if (device_unavailable_exc && nm_en) begin
      sel_vec = EVC_VEC_DEVNA; // RULE_19
    end else if (invalid_task_state_exc) begin
      sel_vec = EVC_VEC_TASKST; // RULE_12
    end else if (segment_absent_exc) begin
      sel_vec = EVC_VEC_SEGABS;
    end else if (stack_exc) begin
      sel_vec = EVC_VEC_STACK; // RULE_13
    end else if (general_protection_exc) begin
      sel_vec = EVC_VEC_GPROT; // RULE_14
    end else if (page_fault_exc && pg_en) begin
      sel_vec = EVC_VEC_PAGE; // RULE_15
    end else if (fp_unmasked) begin
      sel_vec = EVC_VEC_FPPEND; // RULE_01
    end else if (alignment_check_exc && ac_en) begin
      sel_vec = EVC_VEC_ALIGN; // RULE_19
    end else if (media_unmasked) begin
      sel_vec = EVC_VEC_SIMDFP; // RULE_02
    end else if (security_exc) begin
      sel_vec = EVC_VEC_SECURE; // RULE_17
    end else if (soft_int_req) begin
      sel_vec = soft_int_vector; // RULE_08
      sel_src = EVC_SRC_SOFT;
    end else if (nmi_pend_q && !nmi_block_q) begin
      sel_vec = EVC_VEC_NMI; // RULE_21
      sel_src = EVC_SRC_NMI;
    end else if (maskable_external_irq && interrupt_enable_flag) begin
      sel_vec = ext_irq_vector; // RULE_20
      sel_src = EVC_SRC_EXT;
    end else begin
      sel_hit = 1'b0;
    end
    // An exception arriving while a previous one is still being handled escalates.
    if (exc_any && handling_q) begin
      sel_vec = EVC_VEC_DOUBLE; // RULE_11
    end
  end

  // Classification of the selected vector.
  evc_class_lut u_lut (
    .vector(sel_vec),
    .kind(lut_kind),
    .prec(lut_prec),
    .cls(lut_cls),
    .reserved(lut_rsv)
  );

  // Registered delivery record; the vector indexes the 256-entry table.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deliver_valid <= 1'b0;
      deliver_vector <= 8'h00;
      deliver_kind <= EVC_KIND_NONE;
      deliver_prec <= EVC_PREC_NA;
      deliver_class <= EVC_CLS_NONE;
      deliver_src <= EVC_SRC_EXC;
      deliver_reserved <= 1'b0;
    end else begin
      deliver_valid <= sel_hit; // RULE_06
      deliver_vector <= sel_vec;
      deliver_src <= sel_src;
      if (sel_src == EVC_SRC_EXC) begin
        deliver_kind <= lut_kind;
        deliver_prec <= lut_prec;
        deliver_class <= lut_cls;
        deliver_reserved <= 1'b0;
        if (sel_vec == EVC_VEC_DEBUG && debug_is_trap) begin
          deliver_kind <= EVC_KIND_TRAP; // RULE_10
        end
      end else if (sel_src == EVC_SRC_NMI) begin
        deliver_kind <= lut_kind;
        deliver_prec <= lut_prec;
        deliver_class <= lut_cls;
        deliver_reserved <= 1'b0;
      end else begin
        deliver_kind <= EVC_KIND_NONE; // RULE_18
        deliver_prec <= EVC_PREC_NA;
        deliver_class <= EVC_CLS_BENIGN;
        deliver_reserved <= lut_rsv; // RULE_07
      end
    end
  end

  // Side pulses: recognition, default handling of masked FP, external acknowledge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_recognized <= 1'b0;
      fp_default_handled <= 1'b0;
      media_default_handled <= 1'b0;
      ext_irq_ack <= 1'b0;
    end else begin
      exc_recognized <= exc_any | fp_masked | media_masked; // RULE_04
      fp_default_handled <= fp_masked; // RULE_01
      media_default_handled <= media_masked; // RULE_03
      ext_irq_ack <= sel_hit && sel_src == EVC_SRC_EXT; // RULE_20
    end
  end

  // NMI pending latch; a new request wins over the clear of delivery.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_req) begin
      nmi_pend_q <= 1'b1;
    end else if (sel_hit && sel_src == EVC_SRC_NMI) begin
      nmi_pend_q <= 1'b0;
    end
  end
  // NMI blocking from acceptance until interrupt return; acceptance wins a tie.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_block_q <= 1'b0;
    end else if (sel_hit && sel_src == EVC_SRC_NMI) begin
      nmi_block_q <= 1'b1; // RULE_21
    end else if (interrupt_return_instr) begin
      nmi_block_q <= 1'b0; // RULE_21
    end
  end
  // Handling window of an exception, closed when the handler has been entered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      handling_q <= 1'b0;
    end else if (sel_hit && sel_src == EVC_SRC_EXC) begin
      handling_q <= 1'b1; // RULE_11
    end else if (handler_entered) begin
      handling_q <= 1'b0;
    end
  end
  assign nmi_blocked = nmi_block_q;
  assign handling_busy = handling_q;
  assign control_reg_zero = cr0_q;
  assign control_reg_four = cr4_q;

  // Steps of an NMI being accepted and then blocking the next one.
  sequence s_nmi_taken;
    deliver_valid && deliver_src == EVC_SRC_NMI;
  endsequence
  a_nmi_block_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_21
    s_nmi_taken ##0 (!interrupt_return_instr)[*2] |=>
      !(deliver_valid && deliver_src == EVC_SRC_NMI))
    else $error("second NMI delivered before interrupt return");
  a_ext_needs_if: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
    ext_irq_ack |-> $past(interrupt_enable_flag) && deliver_vector == $past(ext_irq_vector))
    else $error("external interrupt taken while enable flag clear");
  a_ext_benign: assert property (@(posedge clk) disable iff (!rst_n) // RULE_18
    deliver_valid && deliver_src == EVC_SRC_EXT |->
      deliver_kind == EVC_KIND_NONE && deliver_prec == EVC_PREC_NA &&
      deliver_class == EVC_CLS_BENIGN)
    else $error("external interrupt carries a type or precision");
  a_page_needs_pg: assert property (@(posedge clk) disable iff (!rst_n) // RULE_15
    deliver_valid && deliver_vector == EVC_VEC_PAGE && deliver_src == EVC_SRC_EXC |->
      $past(cr0_q[EVC_CR0_PG]))
    else $error("page fault raised with paging off");
  a_media_masked: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    media_masked && !exc_any |=> !(deliver_valid && deliver_vector == EVC_VEC_SIMDFP) &&
      media_default_handled)
    else $error("masked media condition was delivered");
  a_fp_unmasked: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    fp_unmasked && !handling_q && !(machine_check_exc && mc_en) |=>
      deliver_valid && deliver_vector <= EVC_VEC_FPPEND)
    else $error("unmasked legacy FP condition not delivered");
  a_align_disabled: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    alignment_check_exc && !ac_en && !exc_any && !fp_masked && !media_masked |=>
      !exc_recognized)
    else $error("disabled alignment check was recognized");
  a_double_fault: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    handling_q && exc_any |=> deliver_vector == EVC_VEC_DOUBLE &&
      deliver_kind == EVC_KIND_ABORT && deliver_prec == EVC_PREC_NO)
    else $error("exception during handling did not escalate");
  a_cr_privilege: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    (cr_wr_zero || cr_wr_four) && current_privilege_level != 2'h0 |=>
      $stable(cr0_q) && $stable(cr4_q))
    else $error("control register changed from unprivileged level");
  a_divide_fault: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    deliver_valid && deliver_vector == EVC_VEC_DIVIDE && deliver_src == EVC_SRC_EXC |->
      deliver_kind == EVC_KIND_FAULT)
    else $error("divide error not classed as fault");
endmodule : evc_core
`default_nettype wire

// >>> sim/evc_irq_ctrl_model.sv
// Behavioural external interrupt controller that holds its request until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module evc_irq_ctrl_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bench trigger and the core's acknowledge.
  input wire logic raise,
  input wire logic [7:0] raise_vector,
  input wire logic ext_irq_ack,
  // Request toward the core.
  output logic maskable_external_irq,
  output logic [7:0] ext_irq_vector
);
  logic pend_q;
  logic [7:0] vec_q;
  // Keep the request pending until the core acknowledges it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      vec_q <= 8'h00;
    end else if (raise) begin
      pend_q <= 1'b1;
      vec_q <= raise_vector;
    end else if (ext_irq_ack) begin
      pend_q <= 1'b0;
    end
  end
  // The request drops in the acknowledge cycle; a released vector shows the inverse value.
  assign maskable_external_irq = pend_q & ~ext_irq_ack;
  assign ext_irq_vector = maskable_external_irq ? vec_q : ~vec_q;
endmodule : evc_irq_ctrl_model
`default_nettype wire

// >>> sim/exception_vector_classifier_bench.sv
// Self-checking bench for the exception front end with a queue-based reference model.
`timescale 1ns/1ps
`default_nettype none
module exception_vector_classifier_bench;
  import evc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cr_wr_zero = 1'b0, cr_wr_four = 1'b0, debug_is_trap = 1'b0;
  logic [31:0] cr_wdata = 32'h0;
  logic [1:0] current_privilege_level = 2'h0;
  logic [14:0] ex = '0;
  logic fp_exc_valid = 1'b0, media_exc_valid = 1'b0, soft_int_req = 1'b0, raise = 1'b0;
  logic [5:0] fp_status_word = 6'h0, fp_control_word = 6'h0, media_exc_flags = 6'h0;
  logic [15:0] media_ctrl_status_reg = 16'h0;
  logic [7:0] soft_int_vector = 8'h0, raise_vector = 8'h0, ext_irq_vector, deliver_vector;
  logic interrupt_enable_flag = 1'b0, nmi_req = 1'b0, interrupt_return_instr = 1'b0;
  logic handler_entered = 1'b0, maskable_external_irq, deliver_valid, deliver_reserved;
  logic ext_irq_ack, exc_recognized, fp_default_handled, media_default_handled;
  logic nmi_blocked, handling_busy;
  logic [31:0] control_reg_zero, control_reg_four;
  evc_kind_type deliver_kind;
  evc_prec_type deliver_prec;
  evc_class_type deliver_class;
  evc_src_type deliver_src;
  int error_cnt = 0, checks_done = 0, v, e, unm;
  int expq[$];
  int vtab[15] = '{0, 1, 3, 4, 5, 6, 7, 10, 11, 12, 13, 14, 17, 18, 30};
  int dis[4] = '{6, 11, 12, 13};
  int svec[6] = '{0, 255, 9, 31, 20, 64};

  evc_core i_dut (
    .clk, .rst_n, .cr_wr_zero, .cr_wr_four, .cr_wdata, .current_privilege_level,
    .divide_error_exc(ex[0]), .debug_exc(ex[1]), .debug_is_trap, .breakpoint_exc(ex[2]),
    .overflow_exc(ex[3]), .bound_range_exc(ex[4]), .invalid_opcode_exc(ex[5]),
    .device_unavailable_exc(ex[6]), .invalid_task_state_exc(ex[7]),
    .segment_absent_exc(ex[8]), .stack_exc(ex[9]), .general_protection_exc(ex[10]),
    .page_fault_exc(ex[11]), .alignment_check_exc(ex[12]), .machine_check_exc(ex[13]),
    .security_exc(ex[14]), .fp_exc_valid, .fp_status_word, .fp_control_word,
    .media_exc_valid, .media_exc_flags, .media_ctrl_status_reg, .soft_int_req,
    .soft_int_vector, .maskable_external_irq, .ext_irq_vector, .interrupt_enable_flag,
    .nmi_req, .interrupt_return_instr, .handler_entered, .deliver_valid, .deliver_vector,
    .deliver_kind, .deliver_prec, .deliver_class, .deliver_src, .deliver_reserved,
    .ext_irq_ack, .exc_recognized, .fp_default_handled, .media_default_handled,
    .nmi_blocked, .handling_busy, .control_reg_zero, .control_reg_four
  );
  evc_irq_ctrl_model i_irq (
    .clk, .rst_n, .raise, .raise_vector, .ext_irq_ack, .maskable_external_irq, .ext_irq_vector
  );
  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // Expected event word: source, reserved, kind, precision, class, vector.
  function automatic int item(int src, int res, int code, int vec);
    return (src << 15) | (res << 14) | (code << 8) | vec;
  endfunction : item
  function automatic int rsv(int vec);
    return int'(vec == 9 || vec == 15 || (vec >= 20 && vec <= 29) || vec == 31);
  endfunction : rsv
  // Kind, precision and class of each fixed vector.
  function automatic int code_of(int vec);
    case (vec)
      0, 10, 11, 12, 13, 14: return 22;
      3, 4: return 37;
      5, 6, 7, 17: return 21;
      8, 18: return 56;
      16: return 24;
      1, 19: return 20;
      30: return 6;
      default: return 0;
    endcase
  endfunction : code_of

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Close the handling window so no escalation follows.
  task automatic close_h();
    handler_entered = 1'b1;
    step();
    handler_entered = 1'b0;
    step(2);
  endtask : close_h
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Compare every delivered event with the oldest expected one.
  always @(negedge clk) begin
    if (rst_n && deliver_valid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : -1;
      check({15'h0, deliver_src, deliver_reserved, deliver_kind, deliver_prec, deliver_class,
             deliver_vector}, e);
      check(ext_irq_ack, deliver_src == EVC_SRC_EXT);
      check(exc_recognized, deliver_src == EVC_SRC_EXC);
      check(handling_busy, deliver_src == EVC_SRC_EXC);
    end
  end

  // Watchdog against a hang.
  initial begin
    #8000;
    error_cnt++;
    test_done();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h60d4));
    step(20);
    rst_n = 1'b1;
    step();
    check(control_reg_zero, EVC_CR0_RESET);
    foreach (dis[i]) begin
      ex[dis[i]] = 1'b1;
      step();
      ex = '0;
      check(exc_recognized, 1'b0);
      step();
    end
    // Writes count only at privilege level zero.
    current_privilege_level = 2'h3;
    cr_wdata = '1;
    cr_wr_zero = 1'b1;
    step();
    cr_wr_zero = 1'b0;
    step();
    check(control_reg_zero, 32'h0);
    current_privilege_level = 2'h0;
    cr_wdata = 32'h8004_0008;
    cr_wr_zero = 1'b1;
    step();
    cr_wr_zero = 1'b0;
    cr_wdata = 32'h0000_0040;
    cr_wr_four = 1'b1;
    step();
    cr_wr_four = 1'b0;
    step();
    check(control_reg_zero, 32'h8004_0008);
    check(control_reg_four, 32'h0000_0040);
    foreach (vtab[i]) begin
      debug_is_trap = 1'($urandom_range(1, 0));
      expq.push_back(item(0, 0, (i == 1 && debug_is_trap) ? 36 : code_of(vtab[i]), vtab[i]));
      ex[i] = 1'b1;
      step();
      ex = '0;
      close_h();
    end
    // An exception inside the handling window escalates.
    expq.push_back(item(0, 0, 22, 0));
    expq.push_back(item(0, 0, 56, 8));
    ex[0] = 1'b1;
    step();
    ex = 15'h0400;
    step();
    ex = '0;
    close_h();
    for (int k = 0; k < 8; k++) begin
      e = $urandom_range(63, 1);
      v = $urandom_range(63, 0);
      unm = e & ~v;
      if (unm != 0) expq.push_back(item(0, 0, (k % 2) ? 20 : 24, (k % 2) ? 19 : 16));
      if (k % 2) begin
        media_exc_valid = 1'b1;
        media_exc_flags = 6'(e);
        media_ctrl_status_reg = 16'($urandom_range(65535, 0)) & 16'hE07F | 16'(v << 7);
      end else begin
        fp_exc_valid = 1'b1;
        fp_status_word = 6'(e);
        fp_control_word = 6'(v);
      end
      step();
      {fp_exc_valid, media_exc_valid} = 2'b00;
      check((k % 2) ? media_default_handled : fp_default_handled, unm == 0);
      check(exc_recognized, 1'b1);
      close_h();
    end
    svec[5] = $urandom_range(255, 32);
    foreach (svec[i]) begin
      expq.push_back(item(1, rsv(svec[i]), 1, svec[i]));
      soft_int_req = 1'b1;
      soft_int_vector = 8'(svec[i]);
      step();
      soft_int_req = 1'b0;
      close_h();
    end
    // External request waits while the enable flag is clear.
    raise = 1'b1;
    raise_vector = 8'($urandom_range(255, 0));
    step();
    raise = 1'b0;
    step(5);
    check(maskable_external_irq, 1'b1);
    expq.push_back(item(3, rsv(raise_vector), 1, raise_vector));
    interrupt_enable_flag = 1'b1;
    step(3);
    check(maskable_external_irq, 1'b0);
    interrupt_enable_flag = 1'b0;
    // A second NMI waits for interrupt return.
    expq.push_back(item(2, 0, 0, 2));
    nmi_req = 1'b1;
    step();
    nmi_req = 1'b0;
    close_h();
    check(nmi_blocked, 1'b1);
    nmi_req = 1'b1;
    step();
    nmi_req = 1'b0;
    step(4);
    expq.push_back(item(2, 0, 0, 2));
    interrupt_return_instr = 1'b1;
    step();
    interrupt_return_instr = 1'b0;
    step(4);
    check(nmi_blocked, 1'b1);
    close_h();
    check(expq.size(), 0);
    test_done();
  end
endmodule : exception_vector_classifier_bench
`default_nettype wire
